/* pmu_pkg.sv */
package pmu_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CTR_W = 44;
  localparam int unsigned NUM_EV = 4;
  localparam int unsigned NUM_SUB = 8;
  localparam int unsigned SUB_W = 4;
  localparam int unsigned SEL_W = 7;
  localparam int unsigned THR_W = 8;
  localparam int unsigned EVSEL_W = 8;
  localparam int unsigned NUM_CORES = 4;
  localparam int unsigned EVT_BUS_W = NUM_EV * NUM_SUB * SUB_W;

  // Register space indices
  localparam logic [ADDR_W-1:0] ADDR_GLB_CTL = 12'hC00;
  localparam logic [ADDR_W-1:0] ADDR_GLB_STS = 12'hC01;
  localparam logic [ADDR_W-1:0] ADDR_MISC = 12'hC06;
  localparam logic [ADDR_W-1:0] ADDR_BOX_CTL = 12'hD04;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'hD10;
  localparam logic [ADDR_W-1:0] ADDR_FLT_LO = 12'hD14;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 12'hD16;
  localparam logic [ADDR_W-1:0] ADDR_FLT_HI = 12'hD1A;

  // Counter configuration fields
  localparam int unsigned CFG_EVSEL_LSB = 0;
  localparam int unsigned CFG_UMASK_LSB = 8;
  localparam int unsigned CFG_EDGE_BIT = 18;
  localparam int unsigned CFG_OVEN_BIT = 20;
  localparam int unsigned CFG_EN_BIT = 22;
  localparam int unsigned CFG_THR_LSB = 24;

  // Box and global control fields, and the global status overflow bit
  localparam int unsigned BOX_FREEZE_BIT = 8;
  localparam int unsigned GLB_ROUTE_LSB = 0;
  localparam int unsigned GLB_EN_BIT = 29;
  localparam int unsigned GLB_STS_OVF_BIT = 0;

  localparam logic [DATA_W-1:0] REG_RST = 64'h0;
  localparam logic [CTR_W-1:0] CTR_RST = 44'h0;
endpackage

/* pmu_evt_if.sv */
`timescale 1ns/1ns
interface pmu_evt_if;
  import pmu_pkg::*;
  logic [SEL_W-1:0] sel_cnt;
  logic [THR_W-1:0] thresh;
  logic edge_det;
  logic active;
  logic [SEL_W-1:0] inc;
  modport path (input sel_cnt, thresh, edge_det, active, output inc);
  modport ctr (input inc);
endinterface // pmu_evt_if

/* pmu_evpath.sv */
`timescale 1ns/1ns
module pmu_evpath
(
  input wire logic clk_i,          // Block clock
  input wire logic rst_n_i,        // Sync reset, low
  pmu_evt_if.path evt              // Event path signals
);
  import pmu_pkg::*;

  logic prev_hit;
  logic thr_nz;
  logic cmp_hit;
  logic rise;
  logic [SEL_W-1:0] thr_inc;

  assign thr_nz = (evt.thresh != '0);
  // Threshold compare comes first; zero threshold means any event
  assign cmp_hit = thr_nz ? ({1'b0, evt.sel_cnt} >= evt.thresh)
                          : (evt.sel_cnt != '0);
  assign rise = cmp_hit & ~prev_hit;
  assign thr_inc = thr_nz ? SEL_W'(cmp_hit) : evt.sel_cnt;
  assign evt.inc = !evt.active ? '0 :
                   evt.edge_det ? SEL_W'(rise) : thr_inc;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_hit <= 1'b0;
    end else begin
      prev_hit <= evt.active & cmp_hit;
    end
  end
endmodule // pmu_evpath

/* pmu_ctr.sv */
`timescale 1ns/1ns
module pmu_ctr
(
  input wire logic clk_i,              // Block clock
  input wire logic rst_n_i,            // Sync reset, low
  input wire logic load_i,             // Software write
  input wire logic [pmu_pkg::CTR_W-1:0] load_val_i, // Written value
  pmu_evt_if.ctr evt,                  // Increment source
  output logic [pmu_pkg::CTR_W-1:0] count_o, // Counter value
  output logic wrap_o                  // Wrapped last cycle
);
  import pmu_pkg::*;

  logic [CTR_W:0] sum;

  assign sum = {1'b0, count_o} + (CTR_W+1)'(evt.inc);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o <= CTR_RST;
      wrap_o <= 1'b0;
    end else begin
      // Software load beats the increment
      count_o <= load_i ? load_val_i : sum[CTR_W-1:0];
      wrap_o <= !load_i & sum[CTR_W];
    end
  end
endmodule // pmu_ctr

/* pmu_counter_unit.sv */
`timescale 1ns/1ns
module pmu_counter_unit
(
  input wire logic MCLK_I,                          // Clock, 100 MHz
  input wire logic RST_N_I,                         // Sync reset, low
  input wire logic [pmu_pkg::ADDR_W-1:0] MSR_ADDR_I, // Register index
  input wire logic MSR_WR_I,                        // Write strobe
  input wire logic MSR_RD_I,                        // Read strobe
  input wire logic [pmu_pkg::DATA_W-1:0] MSR_WDATA_I, // Write data
  input wire logic [pmu_pkg::EVT_BUS_W-1:0] EVT_CNT_I, // Sub-event counts
  output logic [pmu_pkg::DATA_W-1:0] MSR_RDATA_O,   // Read data
  output logic MSR_RVALID_O,                        // Read data valid
  output logic [pmu_pkg::NUM_CORES-1:0] OVF_CORE_O, // Overflow per core
  output logic CTR_RUN_O                            // Counting active
);
  import pmu_pkg::*;

  logic [DATA_W-1:0] glb_ctl;
  logic [DATA_W-1:0] misc;
  logic [DATA_W-1:0] box_ctl;
  logic [DATA_W-1:0] cfg;
  logic [DATA_W-1:0] flt_lo;
  logic [DATA_W-1:0] flt_hi;
  logic sts_ovf;
  logic [CTR_W-1:0] ctr_val;
  logic ctr_wrap;
  logic [SEL_W-1:0] sum_sel;

  // Write decode
  logic wr_glb_ctl;
  logic wr_glb_sts;
  logic wr_misc;
  logic wr_box;
  logic wr_cfg;
  logic wr_flt_lo;
  logic wr_data;
  logic wr_flt_hi;
  assign wr_glb_ctl = MSR_WR_I && (MSR_ADDR_I == ADDR_GLB_CTL);
  assign wr_glb_sts = MSR_WR_I && (MSR_ADDR_I == ADDR_GLB_STS);
  assign wr_misc = MSR_WR_I && (MSR_ADDR_I == ADDR_MISC);
  assign wr_box = MSR_WR_I && (MSR_ADDR_I == ADDR_BOX_CTL);
  assign wr_cfg = MSR_WR_I && (MSR_ADDR_I == ADDR_CFG);
  assign wr_flt_lo = MSR_WR_I && (MSR_ADDR_I == ADDR_FLT_LO);
  assign wr_data = MSR_WR_I && (MSR_ADDR_I == ADDR_DATA);
  assign wr_flt_hi = MSR_WR_I && (MSR_ADDR_I == ADDR_FLT_HI);

  // Configuration fields
  logic [EVSEL_W-1:0] event_select_field;
  logic [NUM_SUB-1:0] umask;
  logic [THR_W-1:0] thr;
  logic cfg_en;
  logic cfg_edge;
  logic cfg_oven;
  logic box_en;
  logic glb_en;
  logic run;
  logic ev_ok;
  localparam int unsigned EV_IDX_W = $clog2(NUM_EV);
  logic [EV_IDX_W-1:0] ev_idx;
  logic [NUM_CORES-1:0] route;
  assign event_select_field = cfg[CFG_EVSEL_LSB +: EVSEL_W];
  assign umask = cfg[CFG_UMASK_LSB +: NUM_SUB];
  assign thr = cfg[CFG_THR_LSB +: THR_W];
  assign cfg_en = cfg[CFG_EN_BIT];
  assign cfg_edge = cfg[CFG_EDGE_BIT];
  assign cfg_oven = cfg[CFG_OVEN_BIT];
  assign box_en = !box_ctl[BOX_FREEZE_BIT];
  assign glb_en = glb_ctl[GLB_EN_BIT];
  assign route = glb_ctl[GLB_ROUTE_LSB +: NUM_CORES];
  assign run = cfg_en && box_en && glb_en;
  assign ev_ok = (event_select_field < EVSEL_W'(NUM_EV));
  assign ev_idx = event_select_field[EV_IDX_W-1:0];

  // Selected event: unit-mask enabled sub-events summed in a chain
  logic [NUM_SUB:0][SEL_W-1:0] part_sum;
  assign part_sum[0] = '0;
  for (genvar s = 0; s < NUM_SUB; s++) begin : g_sub
    logic [SUB_W-1:0] raw;
    logic [SEL_W-1:0] pick;
    assign raw = EVT_CNT_I[(ev_idx * NUM_SUB + s) * SUB_W +: SUB_W];
    assign pick = (ev_ok && umask[s]) ? SEL_W'(raw) : '0;
    assign part_sum[s+1] = part_sum[s] + pick;
  end
  assign sum_sel = part_sum[NUM_SUB];

  pmu_evt_if evt ();
  assign evt.sel_cnt = sum_sel;
  assign evt.thresh = thr;
  assign evt.edge_det = cfg_edge;
  assign evt.active = run;

  pmu_evpath u_path (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .evt(evt.path)
  );

  pmu_ctr u_ctr (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .load_i(wr_data),
    .load_val_i(MSR_WDATA_I[CTR_W-1:0]),
    .evt(evt.ctr),
    .count_o(ctr_val),
    .wrap_o(ctr_wrap)
  );

  // Overflow notification
  logic ovf_evt;
  logic sts_clr;
  assign ovf_evt = ctr_wrap && cfg_oven;
  assign sts_clr = wr_glb_sts && MSR_WDATA_I[GLB_STS_OVF_BIT];

  // Read mux
  logic [DATA_W-1:0] sts_word;
  logic [DATA_W-1:0] ctr_word;
  logic [DATA_W-1:0] rd_val;
  assign sts_word = DATA_W'(sts_ovf) << GLB_STS_OVF_BIT;
  assign ctr_word = DATA_W'(ctr_val);
  assign rd_val =
    (MSR_ADDR_I == ADDR_GLB_CTL) ? glb_ctl :
    (MSR_ADDR_I == ADDR_GLB_STS) ? sts_word :
    (MSR_ADDR_I == ADDR_MISC) ? misc :
    (MSR_ADDR_I == ADDR_BOX_CTL) ? box_ctl :
    (MSR_ADDR_I == ADDR_CFG) ? cfg :
    (MSR_ADDR_I == ADDR_FLT_LO) ? flt_lo :
    (MSR_ADDR_I == ADDR_DATA) ? ctr_word :
    (MSR_ADDR_I == ADDR_FLT_HI) ? flt_hi : REG_RST;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      glb_ctl <= REG_RST;
      misc <= REG_RST;
      box_ctl <= REG_RST;
      flt_lo <= REG_RST;
      flt_hi <= REG_RST;
    end else begin
      if (wr_glb_ctl) glb_ctl <= MSR_WDATA_I;
      if (wr_misc) misc <= MSR_WDATA_I;
      if (wr_box) box_ctl <= MSR_WDATA_I;
      if (wr_flt_lo) flt_lo <= MSR_WDATA_I;
      if (wr_flt_hi) flt_hi <= MSR_WDATA_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      cfg <= REG_RST;
    end else if (wr_cfg) begin
      cfg <= MSR_WDATA_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      sts_ovf <= 1'b0;
      OVF_CORE_O <= '0;
    end else begin
      // Set wins over a same-cycle clear
      sts_ovf <= ovf_evt | (sts_ovf & ~sts_clr);
      OVF_CORE_O <= ovf_evt ? route : '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      MSR_RDATA_O <= REG_RST;
      MSR_RVALID_O <= 1'b0;
      CTR_RUN_O <= 1'b0;
    end else begin
      MSR_RDATA_O <= MSR_RD_I ? rd_val : MSR_RDATA_O;
      MSR_RVALID_O <= MSR_RD_I;
      CTR_RUN_O <= run;
    end
  end

  // Checks
  logic thr_nz;
  logic hit_cmp;
  logic quiet;
  assign thr_nz = (thr != '0);
  assign hit_cmp = thr_nz ? ({1'b0, sum_sel} >= thr) : (sum_sel != '0);
  assign quiet = run && !wr_data;
  logic addr_known;
  assign addr_known = (MSR_ADDR_I == ADDR_GLB_CTL)
    || (MSR_ADDR_I == ADDR_GLB_STS) || (MSR_ADDR_I == ADDR_MISC)
    || (MSR_ADDR_I == ADDR_BOX_CTL) || (MSR_ADDR_I == ADDR_CFG)
    || (MSR_ADDR_I == ADDR_FLT_LO) || (MSR_ADDR_I == ADDR_DATA)
    || (MSR_ADDR_I == ADDR_FLT_HI);

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  ev_select_a: assert property (
    (!ev_ok || umask == '0) |-> (sum_sel == '0))
    else $error("unselected event reached the counter");

  gate_hold_a: assert property (
    (!cfg_en && !wr_data) |=> (ctr_val == $past(ctr_val)))
    else $error("counter moved while disabled");

  level_gate_a: assert property (
    ((!box_en || !glb_en) && !wr_data) [*2] |=> $stable(ctr_val))
    else $error("counter moved without box or global enable");

  ovf_flag_a: assert property (
    (ctr_wrap && cfg_oven) |=> sts_ovf ##1 (sts_ovf || $past(sts_clr)))
    else $error("overflow not flagged");

  thr_miss_a: assert property (
    (quiet && thr_nz && !cfg_edge && !hit_cmp) |=> $stable(ctr_val))
    else $error("below threshold still counted");

  thr_one_a: assert property (
    (quiet && thr_nz && !cfg_edge && hit_cmp)
    |=> (ctr_val == $past(ctr_val) + CTR_W'(1)))
    else $error("threshold hit did not add one");

  edge_first_a: assert property (
    (quiet && cfg_edge && !hit_cmp) ##1 (quiet && cfg_edge && hit_cmp)
    |=> (ctr_val == $past(ctr_val) + CTR_W'(1)))
    else $error("rising comparison not counted");

  edge_once_a: assert property (
    (quiet && cfg_edge && hit_cmp) [*2] |=> $stable(ctr_val))
    else $error("steady event counted twice");

  cfg_store_a: assert property (
    wr_cfg |=> (cfg == $past(MSR_WDATA_I)))
    else $error("configuration write lost");

  core_route_a: assert property (
    ovf_evt |=> (OVF_CORE_O == $past(route)))
    else $error("overflow not routed to cores");

  raw_add_a: assert property (
    (quiet && !thr_nz && !cfg_edge)
    |=> (ctr_val == $past(ctr_val) + CTR_W'($past(sum_sel))))
    else $error("raw count not accumulated");

  rd_lat_a: assert property (
    MSR_RD_I |=> MSR_RVALID_O ##1 (MSR_RVALID_O == $past(MSR_RD_I)))
    else $error("read answer late");

  run_flag_a: assert property (
    CTR_RUN_O == $past(run))
    else $error("run flag does not follow the enables");

  rd_data_a: assert property (
    MSR_RD_I |=> (MSR_RDATA_O == $past(rd_val)))
    else $error("read data not from the indexed register");

  rd_hold_a: assert property (
    !MSR_RD_I |=> $stable(MSR_RDATA_O))
    else $error("read data moved without a read");

  unmapped_rd_a: assert property (
    (MSR_RD_I && !addr_known) |=> (MSR_RDATA_O == REG_RST))
    else $error("unmapped index did not read zero");

  load_wins_a: assert property (
    wr_data |=> (ctr_val == $past(MSR_WDATA_I[CTR_W-1:0])) && !ctr_wrap)
    else $error("data write lost to counting");

  cfg_keep_a: assert property (
    !wr_cfg |=> $stable(cfg))
    else $error("configuration changed without a write");

  idle_inc_a: assert property (
    !run |-> (evt.inc == '0))
    else $error("increment offered while stopped");

  wrap_real_a: assert property (
    ctr_wrap |-> (ctr_val < $past(ctr_val)))
    else $error("wrap flagged without a wrap");

  sts_clear_a: assert property (
    (sts_clr && !ovf_evt) |=> !sts_ovf)
    else $error("overflow status not cleared");

  oven_off_a: assert property (
    (ctr_wrap && !cfg_oven) |=> (OVF_CORE_O == '0))
    else $error("notified with overflow enable off");

  notify_quiet_a: assert property (
    !ovf_evt |=> (OVF_CORE_O == '0))
    else $error("notification without overflow");

  edge_cnt_c: cover property (quiet && cfg_edge && !hit_cmp ##1 hit_cmp);
  thr_hit_c: cover property (quiet && thr_nz && hit_cmp);
  ovf_c: cover property (ovf_evt ##1 OVF_CORE_O != '0);
  clr_race_c: cover property (ovf_evt && sts_clr);
  freeze_c: cover property (cfg_en && glb_en && !box_en);
endmodule // pmu_counter_unit

/* pmu_counter_unit_test.sv */
`timescale 1ns/1ns
module pmu_counter_unit_test;
  import pmu_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [EVT_BUS_W-1:0] evt = '0;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic [NUM_CORES-1:0] ovf;
  logic run;
  int failures = 0;
  int num_checks = 0;
  localparam logic [DATA_W-1:0] GLB_ON = 64'h1 << GLB_EN_BIT;

  pmu_counter_unit u_pmu_counter_unit (.MCLK_I(mclk), .RST_N_I(rst_n),
    .MSR_ADDR_I(addr), .MSR_WR_I(wr), .MSR_RD_I(rd), .MSR_WDATA_I(wdata),
    .EVT_CNT_I(evt), .MSR_RDATA_O(rdata), .MSR_RVALID_O(rvalid),
    .OVF_CORE_O(ovf), .CTR_RUN_O(run));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [63:0] seen,
                     input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [EVT_BUS_W-1:0] ev_at(int e, int s, int v);
    return EVT_BUS_W'(v) << ((e * NUM_SUB + s) * SUB_W);
  endfunction

  function automatic logic [63:0] cfg(int sel, int um, int edg, int ov,
                                      int thr, int en);
    return 64'(sel) | (64'(um) << CFG_UMASK_LSB) | (64'(edg) << CFG_EDGE_BIT)
      | (64'(ov) << CFG_OVEN_BIT) | (64'(en) << CFG_EN_BIT)
      | (64'(thr) << CFG_THR_LSB);
  endfunction

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [63:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask

  // Answer is registered on the taking edge and checked at the next negedge
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [63:0] exp);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk("read valid", 64'(rvalid), 64'h1);
    chk("read data", rdata, exp);
  endtask

  task automatic ev(input logic [EVT_BUS_W-1:0] v, input int n);
    @(negedge mclk);
    evt = v;
    repeat (n) @(negedge mclk);
    evt = '0;
  endtask

  task automatic setup(input logic [63:0] c);
    wr_reg(ADDR_DATA, 64'h0);
    wr_reg(ADDR_CFG, c);
    repeat (2) @(negedge mclk);
  endtask

  task automatic s_reset;
    rd_reg(ADDR_CFG, 64'h0);
    rd_reg(ADDR_DATA, 64'h0);
    rd_reg(12'hABC, 64'h0);
    wr_reg(ADDR_MISC, 64'hA5A5_0000_FFFF_1234);
    rd_reg(ADDR_MISC, 64'hA5A5_0000_FFFF_1234);
    wr_reg(ADDR_FLT_LO, 64'h0123_4567_89AB_CDEF);
    wr_reg(ADDR_FLT_HI, 64'hFEDC_BA98_7654_3210);
    rd_reg(ADDR_FLT_LO, 64'h0123_4567_89AB_CDEF);
    rd_reg(ADDR_FLT_HI, 64'hFEDC_BA98_7654_3210);
    chk("run idle", 64'(run), 64'h0);
  endtask

  task automatic s_full;
    logic [EVT_BUS_W-1:0] v;
    v = ev_at(1, 1, 3) | ev_at(1, 2, 4) | ev_at(1, 0, 9);
    wr_reg(ADDR_GLB_CTL, GLB_ON);
    setup(cfg(1, 8'h06, 0, 0, 0, 1));
    chk("run on", 64'(run), 64'h1);
    ev(v, 2);
    rd_reg(ADDR_DATA, 64'd14);
    wr_reg(ADDR_BOX_CTL, 64'h1 << BOX_FREEZE_BIT);
    repeat (2) @(negedge mclk);
    ev(v, 2);
    rd_reg(ADDR_DATA, 64'd14);
    wr_reg(ADDR_BOX_CTL, 64'h0);
    wr_reg(ADDR_CFG, cfg(1, 8'h06, 0, 0, 0, 0));
    repeat (2) @(negedge mclk);
    ev(v, 2);
    rd_reg(ADDR_DATA, 64'd14);
  endtask

  task automatic s_select;
    setup(cfg(4, 8'hFF, 0, 0, 0, 1));
    ev(ev_at(0, 0, 5) | ev_at(3, 7, 5), 2);
    rd_reg(ADDR_DATA, 64'h0);
    setup(cfg(2, 8'h80, 0, 0, 0, 1));
    ev(ev_at(2, 7, 6) | ev_at(3, 7, 5) | ev_at(2, 6, 2), 1);
    rd_reg(ADDR_DATA, 64'd6);
    setup(cfg(3, 8'h81, 0, 0, 0, 1));
    ev(ev_at(3, 0, 2) | ev_at(3, 7, 5) | ev_at(2, 0, 9), 1);
    rd_reg(ADDR_DATA, 64'd7);
  endtask

  task automatic s_thresh;
    setup(cfg(0, 8'h03, 0, 0, 3, 1));
    ev(ev_at(0, 0, 1) | ev_at(0, 1, 1), 2);
    rd_reg(ADDR_DATA, 64'h0);
    ev(ev_at(0, 0, 2) | ev_at(0, 1, 1), 3);
    rd_reg(ADDR_DATA, 64'd3);
  endtask

  task automatic s_edge;
    setup(cfg(0, 8'h01, 1, 0, 1, 1));
    ev(ev_at(0, 0, 1), 3);
    ev(ev_at(0, 0, 1), 2);
    rd_reg(ADDR_DATA, 64'd2);
    setup(cfg(0, 8'h01, 1, 0, 4, 1));
    ev(ev_at(0, 0, 2), 2);
    ev(ev_at(0, 0, 5), 3);
    rd_reg(ADDR_DATA, 64'd1);
  endtask

  task automatic s_ovf;
    wr_reg(ADDR_GLB_CTL, GLB_ON | 64'h5);
    wr_reg(ADDR_DATA, 64'hFFF_FFFF_FFFF);
    wr_reg(ADDR_CFG, cfg(0, 8'h01, 0, 1, 0, 1));
    repeat (2) @(negedge mclk);
    evt = ev_at(0, 0, 1);
    @(negedge mclk);
    evt = '0;
    chk("no early notify", 64'(ovf), 64'h0);
    @(negedge mclk);
    chk("notify cores", 64'(ovf), 64'h5);
    @(negedge mclk);
    chk("notify pulse", 64'(ovf), 64'h0);
    rd_reg(ADDR_GLB_STS, 64'h1);
    rd_reg(ADDR_DATA, 64'h0);
    wr_reg(ADDR_GLB_STS, 64'h1);
    rd_reg(ADDR_GLB_STS, 64'h0);
  endtask

  initial begin
    #200000;
    failures++;
    test_done();
  end

  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    s_reset();
    s_full();
    s_select();
    s_thresh();
    s_edge();
    s_ovf();
    test_done();
  end
endmodule // pmu_counter_unit_test
